// ===== logic/nsg_map.svh
// Register offsets, field positions, reset values and counts of the noise seeded generator.
`ifndef NSG_MAP_SVH
`define NSG_MAP_SVH
`define NSG_ADDR_W 8
`define NSG_CTRL_OFF 8'h00
`define NSG_STAT_OFF 8'h04
`define NSG_DATA_OFF 8'h08
`define NSG_CTRL_IE_BIT 3
`define NSG_CTRL_EN_BIT 2
`define NSG_STAT_SFLAG_BIT 6
`define NSG_STAT_CFLAG_BIT 5
`define NSG_STAT_SNOW_BIT 2
`define NSG_STAT_CNOW_BIT 1
`define NSG_STAT_RDY_BIT 0
`define NSG_CTRL_RESET 1'b0
`define NSG_DATA_RESET 32'h00000000
`define NSG_LFSR_RESET 32'h00000001
`define NSG_LFSR_TAPS 32'h80200003
`define NSG_CLK_RATIO 16
`define NSG_SAME_RUN 64
`define NSG_ALT_PAIRS 32
`define NSG_SEED_BITS 40
`define NSG_RESP_OKAY 2'h0
`define NSG_RESP_SLVERR 2'h2
`endif

// ===== logic/nsg_pkg.sv
// Types shared by the noise seeded random generator modules.
package nsg_pkg;
    typedef logic [1:0] nsg_resp_t;
    typedef logic [6:0] nsg_run_t;

    typedef struct packed {
        logic prev;
        nsg_run_t same_cnt;
        nsg_run_t alt_cnt;
        logic fault;
    } nsg_mon_s;

    typedef struct packed {
        logic ie;
        logic en;
        logic [31:0] data;
        logic rdy;
        logic sflag;
        logic cflag;
        logic cnow;
        logic [31:0] lfsr;
        logic [5:0] seed_cnt;
        logic [4:0] gap_cnt;
        logic gclk_s1;
        logic gclk_s2;
        logic gclk_prev;
        logic seed_s1;
        logic seed_s2;
        logic aw_v;
        logic [7:0] aw_addr;
        logic w_v;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        nsg_resp_t bresp;
        logic rvalid;
        logic [31:0] rdata;
        nsg_resp_t rresp;
    } nsg_top_s;
endpackage

// ===== logic/nsg_seed_monitor.sv
// Seed health monitor: flags stuck or purely alternating noise seed runs.
`timescale 1ns/1ps
`include "nsg_map.svh"

module nsg_seed_monitor import nsg_pkg::*; #(
    parameter int SAME_RUN = `NSG_SAME_RUN,
    parameter int ALT_PAIRS = `NSG_ALT_PAIRS
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic run,
    input wire logic tick,
    input wire logic seed,
    output logic fault
);
    localparam nsg_run_t SAME_LIM = nsg_run_t'(SAME_RUN);
    localparam nsg_run_t ALT_LIM = nsg_run_t'(2 * ALT_PAIRS);

    nsg_mon_s cur_r;
    nsg_mon_s cur_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // Run counters are sampled once per generator clock edge.
    always_comb begin
        cur_nxt = cur_r;
        if (!run) begin
            cur_nxt.same_cnt = '0;
            cur_nxt.alt_cnt = '0;
            cur_nxt.fault = 1'b0;
        end else if (tick) begin
            cur_nxt.prev = seed;
            if (seed == cur_r.prev) begin
                if (cur_r.same_cnt != '1) begin
                    cur_nxt.same_cnt = nsg_run_t'(cur_r.same_cnt + 7'h01);
                end
                cur_nxt.alt_cnt = '0;
            end else begin
                if (cur_r.alt_cnt != '1) begin
                    cur_nxt.alt_cnt = nsg_run_t'(cur_r.alt_cnt + 7'h01);
                end
                cur_nxt.same_cnt = '0;
            end
            // The live fault drops as soon as the pattern breaks.
            cur_nxt.fault = (cur_nxt.same_cnt >= SAME_LIM) || (cur_nxt.alt_cnt > ALT_LIM);
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            cur_r <= '0;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign fault = cur_r.fault;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking mon_cb @(posedge clock); endclocking
    default disable iff (!rstn);

    chk_same_run_fault: assert property (
        (run && tick && seed == cur_r.prev && cur_r.same_cnt == SAME_LIM - 7'h01) |=> fault)
        else $error("Stuck seed run did not raise the live fault.");

    chk_break_drops_fault: assert property (
        (run && tick && seed != cur_r.prev && cur_r.alt_cnt == '0) |=> !fault)
        else $error("Live seed fault did not drop when the stuck run broke.");

    chk_stop_clears_fault: assert property (
        !run |=> !fault ##1 (!fault || $past(run)))
        else $error("Live seed fault stayed up while the generator was off.");
endmodule

// ===== logic/nsg_random_top.sv
// Noise seeded random generator with AXI4-Lite register access.
`timescale 1ns/1ps
`include "nsg_map.svh"

// Function
// - Noise seed bits shift into a 32-bit LFSR.
// - The LFSR advances only on generator clock edges.
// - The LFSR word loads into the data register after enough seed bits.
// - Seed and generator clock are watched only while the generator is enabled; faults set status bits.
// - Interrupt enable at control bit 3 gates ready, seed fault and clock fault.
// - Generator enable at control bit 2 turns the generator on.
// - Generator clock slower than 1/16 bus clock sets live and sticky clock fault.
// - A clock fault leaves the held random value intact.
// - Seed stuck through 64 periods, or toggling every period through 65 periods, is a seed fault.
// - Sticky seed fault at status bit 6; writing 0 clears it.
// - Sticky clock fault at status bit 5; only writing 0 clears it.
// - Live seed fault at status bit 2 follows the present seed state.
// - Live clock fault at status bit 1 follows the present clock ratio.
// - Ready at status bit 0 sets on load and clears on data read.
// - About 40 generator clock periods pass between two values.
module nsg_random_top import nsg_pkg::*; #(
    parameter int SEED_BITS = `NSG_SEED_BITS,
    parameter int CLK_RATIO = `NSG_CLK_RATIO
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [`NSG_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`NSG_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic noise_gen_clock,
    input wire logic noise_seed,
    output logic interrupt_request
);
    localparam logic [5:0] SEED_LAST = 6'(SEED_BITS - 1);
    localparam logic [4:0] RATIO_LIM = 5'(CLK_RATIO);
    localparam logic [5:0] CTRL_IDX = 6'(`NSG_CTRL_OFF >> 2);
    localparam logic [5:0] STAT_IDX = 6'(`NSG_STAT_OFF >> 2);
    localparam logic [5:0] DATA_IDX = 6'(`NSG_DATA_OFF >> 2);

    nsg_top_s cur_r;
    nsg_top_s cur_nxt;
    logic tick;
    logic seed_now;
    logic load;
    logic [31:0] lfsr_next;
    logic wr_go;
    logic rd_go;
    logic stat_wr;
    logic data_rd;

    ////////////////////////////////////////////////////////////////////////////////
    // Generator clock edge as a one-cycle enable after the two-stage synchroniser.
    assign tick = cur_r.gclk_s2 && !cur_r.gclk_prev;
    assign lfsr_next = {cur_r.lfsr[30:0], (^(cur_r.lfsr & `NSG_LFSR_TAPS)) ^ cur_r.seed_s2};
    // Loads wait for a healthy clock and seed so a faulty run never replaces the held value.
    assign load = cur_r.en && tick && cur_r.seed_cnt == SEED_LAST && !cur_r.cnow
                  && !seed_now && !cur_r.sflag;

    assign wr_go = cur_r.aw_v && cur_r.w_v && !cur_r.bvalid;
    assign rd_go = s_axi_arvalid && !cur_r.rvalid;
    assign stat_wr = wr_go && cur_r.aw_addr[7:2] == STAT_IDX && cur_r.w_strb[0];
    assign data_rd = rd_go && s_axi_araddr[7:2] == DATA_IDX;

    nsg_seed_monitor #(
        .SAME_RUN(`NSG_SAME_RUN),
        .ALT_PAIRS(`NSG_ALT_PAIRS)
    ) u_seed_monitor (
        .clock(clock),
        .rstn(rstn),
        .run(cur_r.en),
        .tick(tick),
        .seed(cur_r.seed_s2),
        .fault(seed_now)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        cur_nxt = cur_r;
        cur_nxt.gclk_s1 = noise_gen_clock;
        cur_nxt.gclk_s2 = cur_r.gclk_s1;
        cur_nxt.gclk_prev = cur_r.gclk_s2;
        cur_nxt.seed_s1 = noise_seed;
        cur_nxt.seed_s2 = cur_r.seed_s1;

        // Generator core.
        if (!cur_r.en) begin
            cur_nxt.seed_cnt = '0;
            cur_nxt.gap_cnt = '0;
            cur_nxt.cnow = 1'b0;
        end else begin
            if (tick) begin
                cur_nxt.lfsr = lfsr_next;
                cur_nxt.seed_cnt = (cur_r.seed_cnt == SEED_LAST) ? 6'h00
                                   : 6'(cur_r.seed_cnt + 6'h01);
                cur_nxt.gap_cnt = '0;
                if (cur_r.gap_cnt < RATIO_LIM) begin
                    cur_nxt.cnow = 1'b0;
                end
            end else begin
                if (cur_r.gap_cnt != '1) begin
                    cur_nxt.gap_cnt = 5'(cur_r.gap_cnt + 5'h01);
                end
                if (cur_r.gap_cnt >= RATIO_LIM) begin
                    cur_nxt.cnow = 1'b1;
                end
            end
        end

        // Register writes; clears come first so a hardware set in the same cycle wins.
        cur_nxt.aw_v = cur_r.aw_v || s_axi_awvalid;
        if (s_axi_awvalid && !cur_r.aw_v) begin
            cur_nxt.aw_addr = s_axi_awaddr;
        end
        cur_nxt.w_v = cur_r.w_v || s_axi_wvalid;
        if (s_axi_wvalid && !cur_r.w_v) begin
            cur_nxt.w_data = s_axi_wdata;
            cur_nxt.w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            cur_nxt.bvalid = 1'b0;
        end
        if (wr_go) begin
            cur_nxt.aw_v = 1'b0;
            cur_nxt.w_v = 1'b0;
            cur_nxt.bvalid = 1'b1;
            cur_nxt.bresp = `NSG_RESP_SLVERR;
            if (cur_r.aw_addr[7:2] == CTRL_IDX) begin
                cur_nxt.bresp = `NSG_RESP_OKAY;
                if (cur_r.w_strb[0]) begin
                    cur_nxt.ie = cur_r.w_data[`NSG_CTRL_IE_BIT];
                    cur_nxt.en = cur_r.w_data[`NSG_CTRL_EN_BIT];
                end
            end else if (cur_r.aw_addr[7:2] == STAT_IDX) begin
                cur_nxt.bresp = `NSG_RESP_OKAY;
            end
        end
        if (stat_wr && !cur_r.w_data[`NSG_STAT_SFLAG_BIT]) begin
            cur_nxt.sflag = 1'b0;
        end
        if (stat_wr && !cur_r.w_data[`NSG_STAT_CFLAG_BIT]) begin
            cur_nxt.cflag = 1'b0;
        end

        // Register reads; reading the data word consumes the ready bit.
        if (s_axi_rvalid && s_axi_rready) begin
            cur_nxt.rvalid = 1'b0;
        end
        if (rd_go) begin
            cur_nxt.rvalid = 1'b1;
            cur_nxt.rresp = `NSG_RESP_OKAY;
            cur_nxt.rdata = '0;
            case (s_axi_araddr[7:2])
                CTRL_IDX: begin
                    cur_nxt.rdata[`NSG_CTRL_IE_BIT] = cur_r.ie;
                    cur_nxt.rdata[`NSG_CTRL_EN_BIT] = cur_r.en;
                end
                STAT_IDX: begin
                    cur_nxt.rdata[`NSG_STAT_SFLAG_BIT] = cur_r.sflag;
                    cur_nxt.rdata[`NSG_STAT_CFLAG_BIT] = cur_r.cflag;
                    cur_nxt.rdata[`NSG_STAT_SNOW_BIT] = seed_now;
                    cur_nxt.rdata[`NSG_STAT_CNOW_BIT] = cur_r.cnow;
                    cur_nxt.rdata[`NSG_STAT_RDY_BIT] = cur_r.rdy;
                end
                DATA_IDX: begin
                    cur_nxt.rdata = cur_r.data;
                end
                default: begin
                    cur_nxt.rresp = `NSG_RESP_SLVERR;
                end
            endcase
        end
        if (data_rd) begin
            cur_nxt.rdy = 1'b0;
        end

        // Hardware sets.
        if (seed_now) begin
            cur_nxt.sflag = 1'b1;
        end
        if (cur_r.cnow) begin
            cur_nxt.cflag = 1'b1;
        end
        if (load) begin
            cur_nxt.data = lfsr_next;
            cur_nxt.rdy = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            cur_r <= '0;
            cur_r.ie <= `NSG_CTRL_RESET;
            cur_r.en <= `NSG_CTRL_RESET;
            cur_r.data <= `NSG_DATA_RESET;
            cur_r.lfsr <= `NSG_LFSR_RESET;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign s_axi_awready = !cur_r.aw_v;
    assign s_axi_wready = !cur_r.w_v;
    assign s_axi_bvalid = cur_r.bvalid;
    assign s_axi_bresp = cur_r.bresp;
    assign s_axi_arready = !cur_r.rvalid;
    assign s_axi_rvalid = cur_r.rvalid;
    assign s_axi_rdata = cur_r.rdata;
    assign s_axi_rresp = cur_r.rresp;
    assign interrupt_request = cur_r.ie && (cur_r.rdy || cur_r.sflag || cur_r.cflag);

    ////////////////////////////////////////////////////////////////////////////////
    default clocking top_cb @(posedge clock); endclocking
    default disable iff (!rstn);

    chk_load_sets_ready: assert property (
        load |=> cur_r.rdy && cur_r.data == $past(lfsr_next))
        else $error("Load did not capture the LFSR word and raise ready.");

    chk_lfsr_only_tick: assert property (
        !tick |=> $stable(cur_r.lfsr))
        else $error("LFSR moved without a generator clock edge.");

    chk_disabled_no_load: assert property (
        (!cur_r.en && !(cur_r.rdy && data_rd)) |=> $stable(cur_r.data) && $stable(cur_r.rdy))
        else $error("Data or ready changed while the generator was off.");

    chk_slow_clock_fault: assert property (
        (cur_r.en && !tick && cur_r.gap_cnt == RATIO_LIM) |=> cur_r.cnow ##1 cur_r.cflag)
        else $error("Slow generator clock did not raise the clock faults.");

    chk_clock_fault_keeps: assert property (
        cur_r.cnow |=> $stable(cur_r.data))
        else $error("Random value changed during a clock fault.");

    chk_seed_flag_sticky: assert property (
        (cur_r.sflag && !stat_wr) |=> cur_r.sflag[*2] or (cur_r.sflag ##1 $past(stat_wr)))
        else $error("Seed fault flag dropped without a software clear.");

    chk_clock_flag_sticky: assert property (
        (cur_r.cflag && !stat_wr) |=> cur_r.cflag)
        else $error("Clock fault flag dropped without a software clear.");

    chk_read_clears_ready: assert property (
        (data_rd && !load) |=> !cur_r.rdy ##1 (cur_r.rvalid || $past(s_axi_rready)))
        else $error("Data read did not clear ready.");

    chk_ready_raises_irq: assert property (
        ($rose(cur_r.rdy) && cur_r.ie) |-> interrupt_request)
        else $error("Ready with interrupts enabled gave no interrupt.");
endmodule

// ===== tb/nsg_noise_src.sv
// Behavioural noise source: free-running generator clock and a selectable seed pattern.
`timescale 1ns/1ps

module nsg_noise_src (
    input wire logic [1:0] mode,
    input wire logic slow,
    output logic gen_clk,
    output logic seed
);
    logic [15:0] lfsr_r = 16'hACE1;

    initial begin
        gen_clk = 1'b0;
        seed = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // The slow setting gives a 200 ns period, far beyond sixteen bus cycles.
    always begin
        #(slow ? 100 : 20);
        gen_clk = ~gen_clk;
    end

    // The seed moves on the falling edge so that it is steady at each rising edge.
    always @(negedge gen_clk) begin
        lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        case (mode)
            2'h1: seed <= seed;
            2'h2: seed <= ~seed;
            default: seed <= lfsr_r[15];
        endcase
    end
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the noise seeded random generator.
`timescale 1ns/1ps
`include "nsg_map.svh"

module tb_top import nsg_pkg::*;;
    localparam int SB = 8;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, gclk, seed;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [1:0] mode = 2'h0;
    logic slow = 1'b0;
    int bad_count = 0;
    int total_checks = 0;
    int ticks = 0;

    nsg_random_top #(.SEED_BITS(SB)) dut (.clock(clock), .rstn(rstn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .noise_gen_clock(gclk), .noise_seed(seed),
        .interrupt_request(irq));
    nsg_noise_src src (.mode(mode), .slow(slow), .gen_clk(gclk), .seed(seed));

    always begin
        #2 clock = ~clock;
    end
    always @(posedge gclk) begin
        ticks <= ticks + 1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("Counts: %0d comparisons, %0d mismatches", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Address and data go up together; each drops once taken, the response closes it.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        logic [1:0] r;
        r = 2'h3;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 200 && r === 2'h3; i++) begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
            end
        end
        chk_word({30'h0, r}, {30'h0, e}, "write response");
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] e);
        logic [1:0] r;
        r = 2'h3;
        d = 32'hXXXXXXXX;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 200 && r === 2'h3; i++) begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                r = rresp;
                d = rdata;
                rready <= 1'b0;
            end
        end
        chk_word({30'h0, r}, {30'h0, e}, "read response");
    endtask

    task automatic wait_irq();
        for (int i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge clock);
        chk_word({31'h0, irq}, 32'h00000001, "interrupt");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] d;
        axi_rd(`NSG_CTRL_OFF, d, `NSG_RESP_OKAY);
        chk_word(d, 32'h00000000, "control reset");
        axi_rd(`NSG_STAT_OFF, d, `NSG_RESP_OKAY);
        chk_word(d, 32'h00000000, "status reset");
        axi_rd(`NSG_DATA_OFF, d, `NSG_RESP_OKAY);
        chk_word(d, 32'h00000000, "data reset");
        axi_rd(8'h0C, d, `NSG_RESP_SLVERR);
        chk_word(d, 32'h00000000, "unmapped read");
        axi_wr(`NSG_DATA_OFF, 32'hFFFFFFFF, `NSG_RESP_SLVERR);
        axi_wr(`NSG_CTRL_OFF, 32'h00000008, `NSG_RESP_OKAY);
        axi_rd(`NSG_CTRL_OFF, d, `NSG_RESP_OKAY);
        chk_word(d, 32'h00000008, "control readback");
        chk_word({31'h0, irq}, 32'h00000000, "idle interrupt");
        $display("test registers done");
    endtask

    task automatic t_generate();
        logic [31:0] d, v1, v2;
        int t0;
        axi_wr(`NSG_CTRL_OFF, 32'h0000000C, `NSG_RESP_OKAY);
        wait_irq();
        t0 = ticks;
        axi_rd(`NSG_STAT_OFF, d, `NSG_RESP_OKAY);
        chk_word(d, 32'h00000001, "ready set");
        axi_rd(`NSG_DATA_OFF, v1, `NSG_RESP_OKAY);
        axi_rd(`NSG_STAT_OFF, d, `NSG_RESP_OKAY);
        chk_word(d, 32'h00000000, "ready cleared by read");
        chk_word({31'h0, irq}, 32'h00000000, "interrupt after read");
        wait_irq();
        chk_word(ticks - t0, SB, "ticks between values");
        axi_rd(`NSG_DATA_OFF, v2, `NSG_RESP_OKAY);
        chk_word({31'h0, v1 !== v2}, 32'h00000001, "values differ");
        $display("test generate done");
    endtask

    task automatic t_disable();
        logic [31:0] d, v;
        axi_wr(`NSG_CTRL_OFF, 32'h00000008, `NSG_RESP_OKAY);
        axi_rd(`NSG_DATA_OFF, v, `NSG_RESP_OKAY);
        repeat (3 * SB) @(posedge gclk);
        axi_rd(`NSG_STAT_OFF, d, `NSG_RESP_OKAY);
        chk_word(d, 32'h00000000, "no ready when off");
        chk_word({31'h0, irq}, 32'h00000000, "no interrupt when off");
        axi_rd(`NSG_DATA_OFF, d, `NSG_RESP_OKAY);
        chk_word(d, v, "data frozen");
        $display("test disable done");
    endtask

    task automatic t_clock();
        logic [31:0] d, v;
        axi_wr(`NSG_CTRL_OFF, 32'h0000000C, `NSG_RESP_OKAY);
        wait_irq();
        axi_rd(`NSG_DATA_OFF, v, `NSG_RESP_OKAY);
        @(posedge clock);
        slow <= 1'b1;
        repeat (3) @(posedge gclk);
        axi_rd(`NSG_STAT_OFF, d, `NSG_RESP_OKAY);
        chk_word(d & 32'h00000023, 32'h00000022, "clock fault set");
        chk_word({31'h0, irq}, 32'h00000001, "fault interrupt");
        axi_rd(`NSG_DATA_OFF, d, `NSG_RESP_OKAY);
        chk_word(d, v, "data kept on clock fault");
        axi_wr(`NSG_CTRL_OFF, 32'h00000004, `NSG_RESP_OKAY);
        chk_word({31'h0, irq}, 32'h00000000, "interrupt masked");
        @(posedge clock);
        slow <= 1'b0;
        repeat (4) @(posedge gclk);
        axi_rd(`NSG_STAT_OFF, d, `NSG_RESP_OKAY);
        chk_word(d & 32'h00000022, 32'h00000020, "live clock fault gone");
        axi_wr(`NSG_STAT_OFF, 32'h00000020, `NSG_RESP_OKAY);
        axi_rd(`NSG_STAT_OFF, d, `NSG_RESP_OKAY);
        chk_word(d & 32'h00000020, 32'h00000020, "flag kept on 1");
        axi_wr(`NSG_STAT_OFF, 32'h00000000, `NSG_RESP_OKAY);
        axi_rd(`NSG_STAT_OFF, d, `NSG_RESP_OKAY);
        chk_word(d & 32'h00000020, 32'h00000000, "flag cleared on 0");
        $display("test clock fault done");
    endtask

    // Forty ticks stay below the threshold; seventy-two pass it for either pattern.
    task automatic t_seed();
        logic [31:0] d;
        for (int m = 1; m <= 2; m++) begin
            @(posedge clock);
            mode <= m[1:0];
            repeat (40) @(posedge gclk);
            axi_rd(`NSG_STAT_OFF, d, `NSG_RESP_OKAY);
            chk_word(d & 32'h00000044, 32'h00000000, "seed below limit");
            repeat (32) @(posedge gclk);
            axi_rd(`NSG_STAT_OFF, d, `NSG_RESP_OKAY);
            chk_word(d & 32'h00000044, 32'h00000044, "seed fault set");
            @(posedge clock);
            mode <= 2'h0;
            repeat (8) @(posedge gclk);
            axi_rd(`NSG_STAT_OFF, d, `NSG_RESP_OKAY);
            chk_word(d & 32'h00000044, 32'h00000040, "live seed fault gone");
            axi_wr(`NSG_STAT_OFF, 32'h00000000, `NSG_RESP_OKAY);
            axi_rd(`NSG_STAT_OFF, d, `NSG_RESP_OKAY);
            chk_word(d & 32'h00000040, 32'h00000000, "seed flag cleared");
        end
        axi_wr(`NSG_CTRL_OFF, 32'h00000000, `NSG_RESP_OKAY);
        axi_wr(`NSG_CTRL_OFF, 32'h0000000C, `NSG_RESP_OKAY);
        wait_irq();
        axi_rd(`NSG_STAT_OFF, d, `NSG_RESP_OKAY);
        chk_word(d & 32'h00000067, 32'h00000001, "restart gives value");
        $display("test seed fault done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        t_regs();
        t_generate();
        t_disable();
        t_clock();
        t_seed();
        stop_test();
    end

    initial begin
        #200000;
        bad_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule
